// ---- hdl/pdm_pkg.sv ----
// package: register map, field layout and mode types of the power-down block
package pdm_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [27:0] STANDBY_CONTROL_ADDR = 28'h5ffffbc;
    localparam logic [7:0] STANDBY_CONTROL_RST = 8'h1f;
    localparam int STANDBY_SELECT_BIT = 7;
    localparam int PORT_FLOAT_SELECT_BIT = 6;
    // bit 5 reads 0, bits 4..0 read 1
    localparam logic [5:0] RESERVED_READ = 6'h1f;
    // ------------------------------------------------------------
    // power-down modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PDM_RUN,
        PDM_SLEEP,
        PDM_STANDBY
    } pdm_mode_type;
endpackage : pdm_pkg

// ---- hdl/pdm_wb_slave.sv ----
// wishbone classic slave holding the standby control register
`timescale 1ns/10ps
`default_nettype none
module pdm_wb_slave (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [27:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic watchdog_run_enable,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    output logic standby_select,
    output logic port_float_select
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // request seen once per cycle; ack drops in the cycle after it
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire hit = wb_adr_i == pdm_pkg::STANDBY_CONTROL_ADDR;
    // write lands on the edge where the master samples ack high
    wire wr_hit = wb_cyc_i && wb_stb_i && wb_ack_o && hit && wb_we_i
        && wb_sel_i;
    // watchdog running blocks setting either control bit
    wire sby_nxt = wb_dat_i[pdm_pkg::STANDBY_SELECT_BIT]
        && !watchdog_run_enable;
    wire hiz_nxt = wb_dat_i[pdm_pkg::PORT_FLOAT_SELECT_BIT]
        && !watchdog_run_enable;
    logic standby_select_r;
    logic port_float_select_r;
    assign standby_select = standby_select_r;
    assign port_float_select = port_float_select_r;
    // ------------------------------------------------------------
    // register and bus answer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            standby_select_r <= pdm_pkg::STANDBY_CONTROL_RST[7];
            port_float_select_r <= pdm_pkg::STANDBY_CONTROL_RST[6];
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 8'h00;
        end else begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit; // unmapped address
            wb_dat_o <= {standby_select_r, port_float_select_r,
                pdm_pkg::RESERVED_READ};
            if (wr_hit) begin
                standby_select_r <= sby_nxt;
                port_float_select_r <= hiz_nxt;
            end
        end
    end
endmodule : pdm_wb_slave
`default_nettype wire

// ---- hdl/pdm_port_hold.sv ----
// i/o port output stage: holds or floats pins during standby
`timescale 1ns/10ps
`default_nettype none
module pdm_port_hold (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic standby,
    input wire logic port_float_select,
    input wire logic [15:0] port_out,
    input wire logic [15:0] port_oe,
    output logic [15:0] pin_o,
    output logic [15:0] pin_oe
);
    logic [15:0] out_r;
    logic [15:0] oe_r;
    // ------------------------------------------------------------
    // freeze while in standby, track otherwise
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            out_r <= 16'h0000;
            oe_r <= 16'h0000;
        end else if (!standby) begin
            out_r <= port_out;
            oe_r <= port_oe;
        end
    end
    assign pin_o = out_r;
    // float all pins in standby when asked
    assign pin_oe = (standby && port_float_select) ? 16'h0000 : oe_r;
endmodule : pdm_port_hold
`default_nettype wire

// ---- hdl/pdm_ctrl.sv ----
// power-down mode controller: sleep and standby sequencing
//
// The Wishbone register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module pdm_ctrl (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [27:0] wb_adr_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic wb_we_i,
    input wire logic wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    input wire logic halt_exec,
    input wire logic irq_accept,
    input wire logic dma_addr_err,
    input wire logic nmi_edge,
    input wire logic watchdog_run_enable,
    output logic cpu_halt,
    output logic clock_stop,
    output logic periph_standby_init,
    output logic wake_sleep,
    output logic wake_standby,
    input wire logic [15:0] port_out,
    input wire logic [15:0] port_oe,
    output logic [15:0] pin_o,
    output logic [15:0] pin_oe
);
    logic standby_select;
    logic port_float_select;
    pdm_pkg::pdm_mode_type mode_r;
    pdm_pkg::pdm_mode_type mode_nxt;
    logic init_r;
    logic wake_sleep_r;
    logic wake_standby_r;
    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    pdm_wb_slave u_regs (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i),
        .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .watchdog_run_enable(watchdog_run_enable),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o),
        .standby_select(standby_select),
        .port_float_select(port_float_select)
    );
    // ------------------------------------------------------------
    // mode transitions
    // ------------------------------------------------------------
    // halt only acts in run, so entry is from program execution only
    wire enter = (mode_r == pdm_pkg::PDM_RUN) && halt_exec;
    wire sleep_exit = irq_accept || dma_addr_err || nmi_edge;
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            pdm_pkg::PDM_RUN: begin
                if (enter && standby_select) begin
                    mode_nxt = pdm_pkg::PDM_STANDBY;
                end else if (enter) begin
                    mode_nxt = pdm_pkg::PDM_SLEEP;
                end
            end
            pdm_pkg::PDM_SLEEP: begin
                if (sleep_exit) begin
                    mode_nxt = pdm_pkg::PDM_RUN;
                end
            end
            pdm_pkg::PDM_STANDBY: begin
                if (nmi_edge) begin
                    mode_nxt = pdm_pkg::PDM_RUN;
                end
            end
            default: mode_nxt = pdm_pkg::PDM_RUN;
        endcase
    end
    // ------------------------------------------------------------
    // state and event pulses
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mode_r <= pdm_pkg::PDM_RUN;
            init_r <= 1'b0;
            wake_sleep_r <= 1'b0;
            wake_standby_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            init_r <= enter && standby_select;
            wake_sleep_r <= (mode_r == pdm_pkg::PDM_SLEEP) && sleep_exit;
            wake_standby_r <= (mode_r == pdm_pkg::PDM_STANDBY) && nmi_edge;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // cpu clock gated, register file untouched, ram not written
    assign cpu_halt = mode_r != pdm_pkg::PDM_RUN;
    assign clock_stop = mode_r == pdm_pkg::PDM_STANDBY;
    assign periph_standby_init = init_r;
    assign wake_sleep = wake_sleep_r;
    assign wake_standby = wake_standby_r;
    pdm_port_hold u_ports (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .standby(clock_stop),
        .port_float_select(port_float_select),
        .port_out(port_out),
        .port_oe(port_oe),
        .pin_o(pin_o),
        .pin_oe(pin_oe)
    );
    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_sleep_entry;
        @(posedge clk_sys) disable iff (sys_rst)
        (mode_r == pdm_pkg::PDM_RUN && halt_exec && !standby_select)
            |=> cpu_halt && !clock_stop;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("sleep not entered");
    property p_standby_entry;
        @(posedge clk_sys) disable iff (sys_rst)
        (mode_r == pdm_pkg::PDM_RUN && halt_exec && standby_select)
            |=> clock_stop && cpu_halt && periph_standby_init;
    endproperty
    a_standby_entry: assert property (p_standby_entry)
        else $error("standby not entered");
    property p_no_spont_halt;
        @(posedge clk_sys) disable iff (sys_rst)
        (!cpu_halt && !halt_exec) |=> !cpu_halt;
    endproperty
    a_no_spont_halt: assert property (p_no_spont_halt)
        else $error("halt without instruction");
    property p_sleep_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        (mode_r == pdm_pkg::PDM_SLEEP && !irq_accept && !dma_addr_err
            && !nmi_edge) |=> cpu_halt;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("sleep left without cause");
    property p_sleep_exit;
        @(posedge clk_sys) disable iff (sys_rst)
        (mode_r == pdm_pkg::PDM_SLEEP && irq_accept)
            |=> !cpu_halt && wake_sleep;
    endproperty
    a_sleep_exit: assert property (p_sleep_exit)
        else $error("sleep not left");
    property p_standby_exit;
        @(posedge clk_sys) disable iff (sys_rst)
        clock_stop && !nmi_edge |=> clock_stop;
    endproperty
    a_standby_exit: assert property (p_standby_exit)
        else $error("standby left without nmi");
    property p_float;
        @(posedge clk_sys) disable iff (sys_rst)
        clock_stop && port_float_select |-> pin_oe == 16'h0000;
    endproperty
    a_float: assert property (p_float)
        else $error("ports not floated");
    property p_hold;
        @(posedge clk_sys) disable iff (sys_rst)
        clock_stop && $past(clock_stop) |-> $stable(pin_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("port output moved in standby");
    property p_wdt_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        (watchdog_run_enable && !standby_select) |=> !standby_select;
    endproperty
    a_wdt_lock: assert property (p_wdt_lock)
        else $error("standby select set while watchdog runs");
    property p_hiz_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        (watchdog_run_enable && !port_float_select) |=> !port_float_select;
    endproperty
    a_hiz_lock: assert property (p_hiz_lock)
        else $error("port float set while watchdog runs");
    property p_reset_val;
        @(posedge clk_sys) $fell(sys_rst) |-> !standby_select
            && !port_float_select && !cpu_halt;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("bad reset value");
    property p_read_val;
        @(posedge clk_sys) disable iff (sys_rst)
        wb_ack_o |-> wb_dat_o[5:0] == 6'h1f;
    endproperty
    a_read_val: assert property (p_read_val)
        else $error("reserved bits read wrong");
endmodule : pdm_ctrl
`default_nettype wire

// ---- verif/pdm_cpu_model.sv ----
// cpu core model: halt instruction, wake events and watchdog level
`timescale 1ns/10ps
`default_nettype none
module pdm_cpu_model (
    input wire logic clk_sys,
    output logic halt_exec,
    output logic irq_accept,
    output logic dma_addr_err,
    output logic nmi_edge,
    output logic watchdog_run_enable
);
    // quiet lines and a stopped watchdog from time zero
    initial begin
        halt_exec = 1'b0;
        irq_accept = 1'b0;
        dma_addr_err = 1'b0;
        nmi_edge = 1'b0;
        watchdog_run_enable = 1'b0;
    end

    // one-cycle pulse: 0 halt, 1 irq, 2 dma error, 3 nmi
    task automatic pulse(input int sel);
        @(posedge clk_sys);
        case (sel)
            0: halt_exec <= 1'b1;
            1: irq_accept <= 1'b1;
            2: dma_addr_err <= 1'b1;
            default: nmi_edge <= 1'b1;
        endcase
        @(posedge clk_sys);
        {halt_exec, irq_accept, dma_addr_err, nmi_edge} <= 4'h0;
    endtask : pulse

    // watchdog level, cleared by software before standby select
    task automatic set_wdog(input logic v);
        @(posedge clk_sys);
        watchdog_run_enable <= v;
    endtask : set_wdog
endmodule : pdm_cpu_model
`default_nettype wire

// ---- verif/power_down_mode_control_tb.sv ----
// testbench of the power-down mode controller
`timescale 1ns/10ps
`default_nettype none
module power_down_mode_control_tb;
    logic clk_sys = 1'b0;
    logic sys_rst;
    logic [27:0] wb_adr_i;
    logic [7:0] wb_dat_i;
    logic wb_we_i;
    logic wb_sel_i;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic [15:0] port_out;
    logic [15:0] port_oe;
    wire [7:0] wb_dat_o;
    wire wb_ack_o, wb_err_o, cpu_halt, clock_stop, periph_standby_init;
    wire wake_sleep, wake_standby, halt_exec, irq_accept, dma_addr_err;
    wire nmi_edge, watchdog_run_enable;
    wire [15:0] pin_o, pin_oe;
    int num_errors = 0;
    int check_count = 0;
    int cyc_count = 0;
    logic [7:0] rd;
    logic err;

    pdm_ctrl i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
        .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .halt_exec(halt_exec), .irq_accept(irq_accept),
        .dma_addr_err(dma_addr_err), .nmi_edge(nmi_edge),
        .watchdog_run_enable(watchdog_run_enable), .cpu_halt(cpu_halt),
        .clock_stop(clock_stop), .periph_standby_init(periph_standby_init),
        .wake_sleep(wake_sleep), .wake_standby(wake_standby),
        .port_out(port_out), .port_oe(port_oe), .pin_o(pin_o),
        .pin_oe(pin_oe));
    pdm_cpu_model i_cpu (.clk_sys(clk_sys), .halt_exec(halt_exec),
        .irq_accept(irq_accept), .dma_addr_err(dma_addr_err),
        .nmi_edge(nmi_edge), .watchdog_run_enable(watchdog_run_enable));

    // 40 mhz clock and a hang limit
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc_count <= cyc_count + 1;
        if (cyc_count == 3000) begin
            num_errors++;
            results();
        end
    end

    task automatic results();
        if (num_errors == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one classic wishbone cycle, held until ack or err
    task automatic wb(input logic we, input logic sel, input logic [27:0] a,
        input logic [7:0] d);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
        rd = wb_dat_o;
        err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb

    task automatic rd_chk(input logic [7:0] exp);
        wb(1'b0, 1'b1, pdm_pkg::STANDBY_CONTROL_ADDR, 8'h00);
        chk("standby_control", rd, exp);
    endtask : rd_chk

    task automatic t_reset();
        rd_chk(8'h1f);
        chk("cpu_halt", cpu_halt, 1'b0);
        chk("pin_oe", pin_oe, 16'hffff);
    endtask : t_reset

    // watchdog interlock, reserved bits, byte enable, unmapped place
    task automatic t_regs();
        i_cpu.set_wdog(1'b1);
        wb(1'b1, 1'b1, pdm_pkg::STANDBY_CONTROL_ADDR, 8'hc0);
        rd_chk(8'h1f);
        i_cpu.set_wdog(1'b0);
        wb(1'b1, 1'b1, pdm_pkg::STANDBY_CONTROL_ADDR, 8'hff);
        rd_chk(8'hdf);
        wb(1'b1, 1'b0, pdm_pkg::STANDBY_CONTROL_ADDR, 8'h00);
        rd_chk(8'hdf);
        wb(1'b1, 1'b1, pdm_pkg::STANDBY_CONTROL_ADDR, 8'h00);
        rd_chk(8'h1f);
        wb(1'b0, 1'b1, 28'h5ffffc0, 8'h00);
        chk("wb_err_o", err, 1'b1);
    endtask : t_regs

    // sleep entry and each of its exits, then a reset in sleep
    task automatic t_sleep();
        for (int ev = 1; ev <= 3; ev++) begin
            i_cpu.pulse(0);
            #1 chk("cpu_halt", cpu_halt, 1'b1);
            chk("clock_stop", clock_stop, 1'b0);
            i_cpu.pulse(ev);
            #1 chk("cpu_halt", cpu_halt, 1'b0);
            chk("wake_sleep", wake_sleep, 1'b1);
        end
        i_cpu.pulse(0);
        @(posedge clk_sys);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        #1 chk("cpu_halt", cpu_halt, 1'b0);
    endtask : t_sleep

    // standby with ports held, then floated
    task automatic t_standby();
        for (int hz = 0; hz < 2; hz++) begin
            wb(1'b1, 1'b1, pdm_pkg::STANDBY_CONTROL_ADDR, {1'b1, hz[0], 6'h0});
            i_cpu.pulse(0);
            #1 chk("clock_stop", clock_stop, 1'b1);
            chk("cpu_halt", cpu_halt, 1'b1);
            chk("init", periph_standby_init, 1'b1);
            @(posedge clk_sys);
            port_out <= 16'h5a5a;
            port_oe <= 16'h0f0f;
            repeat (2) @(posedge clk_sys);
            #1 chk("pin_oe", pin_oe, hz ? 16'h0 : 16'hffff);
            if (hz == 0) chk("pin_o", pin_o, 16'ha5a5);
            i_cpu.pulse(1);
            #1 chk("cpu_halt", cpu_halt, 1'b1);
            i_cpu.pulse(3);
            #1 chk("clock_stop", clock_stop, 1'b0);
            chk("wake_standby", wake_standby, 1'b1);
            rd_chk({1'b1, hz[0], 6'h1f});
            #1 chk("pin_o", pin_o, 16'h5a5a);
            chk("pin_oe", pin_oe, 16'h0f0f);
            @(posedge clk_sys);
            port_out <= 16'ha5a5;
            port_oe <= 16'hffff;
        end
    endtask : t_standby

    initial begin
        sys_rst = 1'b1;
        wb_adr_i = 28'h0;
        wb_dat_i = 8'h0;
        wb_we_i = 1'b0;
        wb_sel_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        port_out = 16'ha5a5;
        port_oe = 16'hffff;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_regs();
        t_sleep();
        t_standby();
        results();
    end
endmodule : power_down_mode_control_tb
`default_nettype wire
